//--- rtl/sdrcr_pkg.sv
// Shared constants and types for the calibration readout / loop-off block.
// Assumes a x16 device with a 13-bit mode word and a 3-bit bank select.
package sdrcr_pkg;

  // Data path geometry
  localparam int BEATS = 8;
  localparam int DQ_W = 16;
  localparam int BURST_W = 128;

  // Mode register selects on the bank bits
  localparam logic [2:0] MR_ZERO = 3'h0;
  localparam logic [2:0] MR_ONE = 3'h1;
  localparam logic [2:0] MR_TWO = 3'h2;
  localparam logic [2:0] MR_THREE = 3'h3;

  // Field positions
  localparam int MR0_BL_LO = 0;
  localparam int MR0_CL_LO = 4;
  localparam int MR1_DLL_OFF_BIT = 0;
  localparam int MR1_AL_LO = 3;
  localparam int MR2_CWL_LO = 3;
  localparam int MR3_LOC_LO = 0;
  localparam int MR3_READOUT_BIT = 2;
  localparam int CHOP_SELECT_ADDR_BIT = 12;
  localparam int HALF_ADDR_BIT = 2;

  // Burst length field encodings
  localparam logic [1:0] BL_FIXED_EIGHT = 2'h0;
  localparam logic [1:0] BL_ON_THE_FLY = 2'h1;
  localparam logic [1:0] BL_FIXED_CHOP = 2'h2;

  // Additive latency encodings
  localparam logic [1:0] AL_ZERO = 2'h0;
  localparam logic [1:0] AL_CL_MINUS_ONE = 2'h1;
  localparam logic [1:0] AL_CL_MINUS_TWO = 2'h2;

  // Latency arithmetic, in link clock cycles
  localparam logic [4:0] CL_BASE = 5'h04;
  localparam logic [4:0] CWL_BASE = 5'h05;
  localparam logic [4:0] LOOP_OFF_LATENCY = 5'h06;
  localparam logic [4:0] ONE_CYCLE = 5'h01;
  localparam logic [4:0] TWO_CYCLES = 5'h02;

  // Readout location and its pattern, beat zero in the least significant bit
  localparam logic [1:0] LOC_PATTERN = 2'h0;
  localparam logic [7:0] READOUT_PATTERN = 8'hAA;

  // Reset values: read latency 6, write latency 6, loop on, readout off
  localparam logic [12:0] MR0_RESET = 13'h0020;
  localparam logic [12:0] MR1_RESET = 13'h0000;
  localparam logic [12:0] MR2_RESET = 13'h0008;
  localparam logic [12:0] MR3_RESET = 13'h0000;

  // Command opcodes as {ras_n, cas_n, we_n}
  typedef enum logic [2:0] {
    SDRCR_CMD_MRS = 3'h0,
    SDRCR_CMD_REF = 3'h1,
    SDRCR_CMD_PRE = 3'h2,
    SDRCR_CMD_ACT = 3'h3,
    SDRCR_CMD_WR = 3'h4,
    SDRCR_CMD_RD = 3'h5,
    SDRCR_CMD_ZQ = 3'h6,
    SDRCR_CMD_NOP = 3'h7
  } sdrcr_op_t;

  // Command and address pins as sampled on the link clock
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [2:0] ba;
    logic [13:0] addr;
  } sdrcr_cmd_t;

  // One read in flight toward the data pins
  typedef struct packed {
    logic valid;
    logic chop;
    logic upper_half;
    logic readout;
    logic [1:0] loc;
    logic [BURST_W-1:0] beats;
  } sdrcr_rec_t;

  // Status levels handed to the system clock domain
  typedef struct packed {
    logic readout_en;
    logic dll_off;
    logic latency_err;
    logic bad_cmd;
    logic unlocked_read;
  } sdrcr_stat_t;

endpackage

//--- rtl/sdrcr_sync.sv
// Two-flop level synchroniser for a bundle of independent status bits.
// Assumes each bit is a slow level; multi-bit coherence is not guaranteed.
`timescale 1ns/10ps
module sdrcr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] level_i,
  output logic [WIDTH-1:0] level_o
);

  logic [WIDTH-1:0] meta;

  // Elaboration check on the bundle width
  if (WIDTH < 1)
    $error("synchroniser needs at least one bit");

  // First stage feeds only the second stage
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      meta <= '0;
      level_o <= '0;
    end
    else
    begin
      meta <= level_i;
      level_o <= meta;
    end
  end

endmodule

//--- rtl/sdrcr_delay_line.sv
// Fixed-depth shift line with a run-time tap, used to delay read records.
// Assumes the tap changes only while the line is empty (mode set rules).
`timescale 1ns/10ps
module sdrcr_delay_line #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] din_i,
  input wire logic [$clog2(DEPTH)-1:0] tap_i,
  output logic [WIDTH-1:0] dout_o
);

  logic [WIDTH-1:0] stage [DEPTH];

  // Elaboration check; the tap must never index past the last stage
  if (DEPTH < 2 || WIDTH < 1 || (DEPTH & (DEPTH - 1)) != 0)
    $error("delay line needs a power-of-two depth of two or more");

  // Every stage moves each cycle; the tap only picks where to look
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      for (int i = 0; i < DEPTH; i++)
        stage[i] <= '0;
    end
    else
    begin
      stage[0] <= din_i;
      for (int i = 1; i < DEPTH; i++)
        stage[i] <= stage[i-1];
    end
  end

  assign dout_o = stage[tap_i];

endmodule

//--- rtl/sdrcr_core.sv
// Device-side command decode, mode registers, calibration readout and
// loop-off read timing. Link logic runs on the controller's clock ck_i;
// status levels cross to clk_i. Assumes the controller meets its own timing.
//
// Overview of operation
// - Readout mode via mode register three bit two
// - Readout stream on bit zero of lanes
// - Upper lane bits copy bit zero or zero
// - Chopped readout half picked by column bit two
// - Bank and unused address bits ignored
// - Address bit twelve chops on the fly
// - Beat zero is location LSB
// - Location 00 returns alternating zero one
// - Readouts use ordinary read latency
// - No-operation changes nothing in progress
// - Deselect blocks new commands only
// - Mode register one bit zero turns loop off
// - Loop-off supports read and write latency six
// - Loop-off data starts one cycle earlier
`timescale 1ns/10ps
module sdrcr_core #(
  parameter int DELAY_DEPTH = 32,
  parameter bit READOUT_COPY = 1'b1
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ck_i,
  input wire sdrcr_pkg::sdrcr_cmd_t cmd_i,
  input wire logic [sdrcr_pkg::BURST_W-1:0] arr_data_i,
  input wire logic dll_locked_i,
  output logic [2*sdrcr_pkg::DQ_W-1:0] dq_o,
  output logic dq_oe_o,
  output sdrcr_pkg::sdrcr_stat_t status_o
);

  localparam int TAP_W = $clog2(DELAY_DEPTH);
  localparam int REC_W = $bits(sdrcr_pkg::sdrcr_rec_t);

  if (DELAY_DEPTH < 24)
    $error("delay depth too small for largest read latency");

  // Latency in cycles from the cas and additive fields
  function automatic logic [4:0] read_lat(input logic [12:0] mr0, input logic [12:0] mr1);
    logic [4:0] cl;
    logic [4:0] al;
    cl = {2'h0, mr0[sdrcr_pkg::MR0_CL_LO +: 3]} + sdrcr_pkg::CL_BASE;
    unique case (mr1[sdrcr_pkg::MR1_AL_LO +: 2])
      sdrcr_pkg::AL_CL_MINUS_ONE: al = cl - sdrcr_pkg::ONE_CYCLE;
      sdrcr_pkg::AL_CL_MINUS_TWO: al = cl - sdrcr_pkg::TWO_CYCLES;
      default: al = 5'h00;
    endcase
    return al + cl;
  endfunction

  // One 16-bit beat out of a burst word
  function automatic logic [sdrcr_pkg::DQ_W-1:0] beat_of(
    input logic [sdrcr_pkg::BURST_W-1:0] beats, input logic [2:0] idx);
    return beats[idx*sdrcr_pkg::DQ_W +: sdrcr_pkg::DQ_W];
  endfunction

  // Readout burst: one bit per beat, replicated or zero on bits 7:1
  function automatic logic [sdrcr_pkg::BURST_W-1:0] readout_beats(input logic [1:0] loc);
    logic [sdrcr_pkg::BURST_W-1:0] word;
    logic bitval;
    logic [7:0] lane;
    word = '0;
    for (int b = 0; b < sdrcr_pkg::BEATS; b++)
    begin
      bitval = (loc == sdrcr_pkg::LOC_PATTERN) ? sdrcr_pkg::READOUT_PATTERN[b] : 1'b0;
      lane = READOUT_COPY ? {8{bitval}} : {7'h00, bitval};
      word[b*sdrcr_pkg::DQ_W +: sdrcr_pkg::DQ_W] = {lane, lane};
    end
    return word;
  endfunction

  // ---------------- link clock domain ----------------
  logic [12:0] mr0;
  logic [12:0] mr1;
  logic [12:0] mr2;
  logic [12:0] mr3;
  logic bad_cmd;
  logic unlocked_read;
  logic lat_err_q;
  logic locked_s;
  sdrcr_pkg::sdrcr_rec_t rec_in;
  sdrcr_pkg::sdrcr_rec_t rec_out;
  logic [REC_W-1:0] rec_out_bits;
  logic [sdrcr_pkg::BURST_W-1:0] em_beats;
  logic [2:0] em_idx;
  logic [1:0] em_left;
  logic em_readout;
  logic [1:0] em_loc;

  // Command decode; a high chip select hides the opcode entirely
  wire sdrcr_pkg::sdrcr_op_t op = sdrcr_pkg::sdrcr_op_t'({cmd_i.ras_n, cmd_i.cas_n, cmd_i.we_n});
  wire selected = !cmd_i.cs_n;
  wire is_mrs = selected && (op == sdrcr_pkg::SDRCR_CMD_MRS);
  wire is_read = selected && (op == sdrcr_pkg::SDRCR_CMD_RD);
  wire is_nop = selected && (op == sdrcr_pkg::SDRCR_CMD_NOP);
  wire is_other = selected && !is_mrs && !is_read && !is_nop;
  wire readout_en = mr3[sdrcr_pkg::MR3_READOUT_BIT];
  wire dll_off = mr1[sdrcr_pkg::MR1_DLL_OFF_BIT];
  wire [1:0] readout_loc = mr3[sdrcr_pkg::MR3_LOC_LO +: 2];

  // Burst length: fixed by mode or chosen per command
  wire [1:0] bl_mode = mr0[sdrcr_pkg::MR0_BL_LO +: 2];
  wire chop = (bl_mode == sdrcr_pkg::BL_FIXED_CHOP) ||
              ((bl_mode == sdrcr_pkg::BL_ON_THE_FLY) && !cmd_i.addr[sdrcr_pkg::CHOP_SELECT_ADDR_BIT]);
  wire upper_half = chop && cmd_i.addr[sdrcr_pkg::HALF_ADDR_BIT];

  // Latency check: loop-off only promises six and six
  wire [4:0] cl_now = {2'h0, mr0[sdrcr_pkg::MR0_CL_LO +: 3]} + sdrcr_pkg::CL_BASE;
  wire [4:0] cwl_now = {2'h0, mr2[sdrcr_pkg::MR2_CWL_LO +: 3]} + sdrcr_pkg::CWL_BASE;
  wire latency_err = dll_off &&
                     ((cl_now != sdrcr_pkg::LOOP_OFF_LATENCY) || (cwl_now != sdrcr_pkg::LOOP_OFF_LATENCY));

  wire [4:0] rl_now = read_lat(mr0, mr1);
  wire [4:0] tap5 = rl_now - (dll_off ? sdrcr_pkg::TWO_CYCLES : sdrcr_pkg::ONE_CYCLE);
  wire [TAP_W-1:0] tap = TAP_W'(tap5);

  // Record pushed on a read; readouts ignore bank, A10, A9:3, A11, A13
  // address bits ignored
  always_comb
  begin
    rec_in = '0;
    rec_in.valid = is_read;
    rec_in.chop = chop;
    rec_in.upper_half = upper_half;
    rec_in.readout = readout_en;
    rec_in.loc = readout_loc;
    rec_in.beats = readout_en ? readout_beats(readout_loc) : arr_data_i;
  end

  // Mode registers; only a selected mode-set command writes them
  // readout enable
  always_ff @(posedge ck_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      mr0 <= sdrcr_pkg::MR0_RESET;
      mr1 <= sdrcr_pkg::MR1_RESET;
      mr2 <= sdrcr_pkg::MR2_RESET;
      mr3 <= sdrcr_pkg::MR3_RESET;
    end
    else if (is_mrs)
    begin
      unique case (cmd_i.ba)
        sdrcr_pkg::MR_ZERO: mr0 <= cmd_i.addr[12:0];
        sdrcr_pkg::MR_ONE: mr1 <= cmd_i.addr[12:0];
        sdrcr_pkg::MR_TWO: mr2 <= cmd_i.addr[12:0];
        sdrcr_pkg::MR_THREE: mr3 <= cmd_i.addr[12:0];
        default: mr0 <= mr0;
      endcase
    end
  end

  // Misuse flags; bad_cmd and unlocked_read only ever set, so no clear can race them; lat_err_q tracks latency_err
  // only reads, mode sets and no-ops in readout
  always_ff @(posedge ck_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      bad_cmd <= 1'b0;
      unlocked_read <= 1'b0;
      lat_err_q <= 1'b0;
    end
    else
    begin
      lat_err_q <= latency_err; // Registered so the sync never sees a glitch
      if (readout_en && is_other)
        bad_cmd <= 1'b1;
      if (is_read && !dll_off && !locked_s)
        unlocked_read <= 1'b1;
    end
  end

  // Lock indication comes from the analog loop, not from this clock
  sdrcr_sync #(
    .WIDTH(1)
  ) u_lock_sync (
    .clk_i(ck_i),
    .reset_i(reset_i),
    .level_i(dll_locked_i),
    .level_o(locked_s)
  );

  sdrcr_delay_line #(
    .WIDTH(REC_W),
    .DEPTH(DELAY_DEPTH)
  ) u_delay (
    .clk_i(ck_i),
    .reset_i(reset_i),
    .din_i(rec_in),
    .tap_i(tap),
    .dout_o(rec_out_bits)
  );
  assign rec_out = sdrcr_pkg::sdrcr_rec_t'(rec_out_bits);

  // Emitter: two beats per link cycle, rising beat in the low half
  wire em_load = rec_out.valid;
  wire [2:0] em_start = rec_out.upper_half ? 3'h4 : 3'h0;
  always_ff @(posedge ck_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      em_beats <= '0;
      em_idx <= 3'h0;
      em_left <= 2'h0;
      em_readout <= 1'b0;
      em_loc <= 2'h0;
      dq_o <= '0;
      dq_oe_o <= 1'b0;
    end
    else if (em_load)
    begin
      em_beats <= rec_out.beats;
      em_idx <= em_start + 3'h2;
      em_left <= rec_out.chop ? 2'h1 : 2'h3;
      em_readout <= rec_out.readout;
      em_loc <= rec_out.loc;
      dq_o <= {beat_of(rec_out.beats, em_start + 3'h1), beat_of(rec_out.beats, em_start)};
      dq_oe_o <= 1'b1;
    end
    else if (em_left != 2'h0)
    begin
      em_idx <= em_idx + 3'h2;
      em_left <= em_left - 2'h1;
      dq_o <= {beat_of(em_beats, em_idx + 3'h1), beat_of(em_beats, em_idx)};
    end
    else
    begin
      dq_o <= '0;
      dq_oe_o <= 1'b0;
    end
  end

  // ---------------- system clock domain ----------------
  // Slow levels only; each bit settles long before software looks
  sdrcr_sync #(
    .WIDTH($bits(sdrcr_pkg::sdrcr_stat_t))
  ) u_stat_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .level_i({readout_en, dll_off, lat_err_q, bad_cmd, unlocked_read}),
    .level_o(status_o)
  );

  // ---------------- checks ----------------
  logic [31:0] rd_hist;

  // Read history, independent of the delay line
  always_ff @(posedge ck_i or posedge reset_i)
  begin
    if (reset_i)
      rd_hist <= '0;
    else
      rd_hist <= {rd_hist[30:0], is_read};
  end

  sequence s_chop_idle;
    !em_load ##1 !em_load;
  endsequence

  sequence s_eight_idle;
    !em_load ##1 !em_load ##1 !em_load ##1 !em_load;
  endsequence

  property p_latency;
    @(posedge ck_i) disable iff (reset_i)
    em_load |-> rd_hist[tap];
  endproperty
  a_latency: assert property (p_latency) else $error("burst start not at read latency");

  property p_lane_copy;
    @(posedge ck_i) disable iff (reset_i)
    (dq_oe_o && em_readout) |->
      (dq_o[7:1] == (READOUT_COPY ? {7{dq_o[0]}} : 7'h00)) && (dq_o[15:8] == dq_o[7:0]);
  endproperty
  a_lane_copy: assert property (p_lane_copy) else $error("readout lanes do not follow bit zero");

  property p_pattern;
    @(posedge ck_i) disable iff (reset_i)
    (dq_oe_o && em_readout && em_loc == sdrcr_pkg::LOC_PATTERN) |-> !dq_o[0] && dq_o[16];
  endproperty
  a_pattern: assert property (p_pattern) else $error("readout pattern not zero then one");

  property p_reserved;
    @(posedge ck_i) disable iff (reset_i)
    (dq_oe_o && em_readout && em_loc != sdrcr_pkg::LOC_PATTERN) |-> dq_o == '0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved location not zero");

  property p_chop_len;
    @(posedge ck_i) disable iff (reset_i)
    (em_load && rec_out.chop) ##1 s_chop_idle |-> dq_oe_o ##1 !dq_oe_o;
  endproperty
  a_chop_len: assert property (p_chop_len) else $error("chopped burst not two cycles");

  property p_eight_len;
    @(posedge ck_i) disable iff (reset_i)
    (em_load && !rec_out.chop) ##1 s_eight_idle |-> dq_oe_o ##1 !dq_oe_o;
  endproperty
  a_eight_len: assert property (p_eight_len) else $error("eight-beat burst not four cycles");

  property p_dll_hold;
    @(posedge ck_i) disable iff (reset_i)
    !(is_mrs && cmd_i.ba == sdrcr_pkg::MR_ONE) |=> $stable(dll_off);
  endproperty
  a_dll_hold: assert property (p_dll_hold) else $error("loop state moved without mode set");

  property p_deselect;
    @(posedge ck_i) disable iff (reset_i)
    (cmd_i.cs_n || is_nop) |=> $stable(mr3) && $stable(mr1) && !u_delay.stage[0][REC_W-1];
  endproperty
  a_deselect: assert property (p_deselect) else $error("deselect or no-op took effect");

  property p_lat_err;
    @(posedge ck_i) disable iff (reset_i)
    (dll_off && mr0[sdrcr_pkg::MR0_CL_LO +: 3] != 3'h2) |-> latency_err;
  endproperty
  a_lat_err: assert property (p_lat_err) else $error("bad loop-off latency not flagged");

endmodule

//--- test/sdrcr_ctrl_model.sv
// Controller model that drives the link command pins on the falling link edge.
// Assumes one caller at a time; each task spends exactly one link cycle.
`timescale 1ns/10ps
module sdrcr_ctrl_model (
  input wire logic ck_i,
  output sdrcr_pkg::sdrcr_cmd_t cmd_o
);
  // Deselected at start, so nothing is taken during reset
  initial cmd_o = '1;

  // aligned read columns
  // Reads always go out nibble-aligned; other commands pass untouched
  task automatic send(input logic [2:0] op, input logic [2:0] ba, input logic [13:0] addr);
    @(negedge ck_i);
    cmd_o <= {1'b0, op, ba, (op == 3'h5) ? {addr[13:2], 2'h0} : addr};
  endtask

  // Deselect with the other pins scrambled, so a stale command never lingers
  task automatic idle(input logic [19:0] junk);
    @(negedge ck_i);
    cmd_o <= {1'b1, junk};
  endtask
endmodule

//--- test/sdrcr_calib_read_dll_off_ctrl_bench.sv
// Self-checking bench for the calibration readout and loop-off block.
// Assumes the controller model drives the link pins; array data comes from here.
`timescale 1ns/10ps
module sdrcr_calib_read_dll_off_ctrl_bench;
  logic clk_i = 1'b0;
  logic ck = 1'b0;
  logic reset_i = 1'b1;
  logic dll_locked = 1'b1;
  logic [127:0] arr_data = '0;
  sdrcr_pkg::sdrcr_cmd_t cmd;
  logic [31:0] dq;
  logic dq_oe;
  sdrcr_pkg::sdrcr_stat_t status;
  logic [4:0] st_bits;
  int seed = 32'hB84F;
  int n_errors = 0;
  int checks_done = 0;
  assign st_bits = status;

  // System clock, and a link clock offset so no edges coincide
  initial
  begin
    forever #10 clk_i = ~clk_i;
  end
  initial
  begin
    #7;
    forever #32 ck = ~ck;
  end

  sdrcr_ctrl_model ctl (.ck_i(ck), .cmd_o(cmd));
  sdrcr_core uut (.clk_i(clk_i), .reset_i(reset_i), .ck_i(ck), .cmd_i(cmd),
    .arr_data_i(arr_data), .dll_locked_i(dll_locked), .dq_o(dq), .dq_oe_o(dq_oe),
    .status_o(status));

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask

  task automatic gap(input int n);
    repeat (n) ctl.idle(20'($random(seed)));
  endtask

  // Mode set, then a few quiet cycles as the mode-set delay
  task automatic mrs(input logic [2:0] ba, input logic [12:0] val);
    ctl.send(3'h0, ba, {1'b0, val});
    gap(4);
  endtask

  // Status crosses domains, so poll it under a bound
  task automatic stat(input string what, input int idx, input logic exp);
    int n;
    n = 0;
    while (st_bits[idx] !== exp && n < 40)
    begin
      @(negedge clk_i);
      n++;
    end
    chk(what, {31'h0, exp}, {31'h0, st_bits[idx]});
    if (st_bits[idx] !== exp)
      tally_and_finish();
  endtask

  // Random column with the chop and half bits set by the caller
  function automatic logic [13:0] raddr(input logic a12, input logic a2);
    logic [13:0] r;
    r = 14'($random(seed));
    return {r[13], a12, r[11:3], a2, r[1:0]};
  endfunction

  // Expected pair of beats; readout copies bit zero across each byte
  function automatic logic [31:0] beat_pair(input logic [127:0] arr, input logic ro,
      input logic [1:0] loc, input int b);
    logic [31:0] w;
    logic pat;
    for (int i = 0; i < 2; i++)
    begin
      pat = ((b + i) % 2 == 1) && (loc == 2'h0);
      w[16*i +: 16] = ro ? {16{pat}} : arr[16*(b+i) +: 16];
    end
    return w;
  endfunction

  // One read: latency, every beat pair, then the strobe dropping
  task automatic do_read(input logic [13:0] addr, input int rl, input int beats,
      input logic ro, input logic [1:0] loc);
    logic [127:0] arr;
    int n;
    int first;
    logic nop;
    arr = {$random(seed), $random(seed), $random(seed), $random(seed)};
    nop = 1'($random(seed));
    first = (beats == 4 && addr[2]) ? 4 : 0;
    ctl.send(3'h5, 3'($random(seed)), addr);
    arr_data <= arr;
    n = 0;
    // realign on strobe
    // Each pass looks half a cycle after an edge, so n runs one past the latency
    while (dq_oe !== 1'b1 && n < 20)
    begin
      if (nop)
        ctl.send(3'h7, 3'h0, 14'($random(seed)));
      else
        gap(1);
      n++;
    end
    chk("read latency", 32'(rl), 32'(n - 1));
    if (n >= 20)
      tally_and_finish();
    for (int k = 0; k < beats / 2; k++)
    begin
      chk("read data", beat_pair(arr, ro, loc, first + 2 * k), dq);
      gap(1);
    end
    chk("strobe off", 32'h0, {31'h0, dq_oe});
  endtask

  initial
  begin
    repeat (20) @(posedge clk_i);
    @(negedge clk_i);
    reset_i = 1'b0;
    gap(4);
    chk("reset strobe", 32'h0, {31'h0, dq_oe});
    chk("reset data", 32'h0, dq);
    chk("reset status", 32'h0, {27'h0, st_bits});
    repeat (3) do_read(raddr(1'($random(seed)), 1'($random(seed))), 6, 8, 1'b0, 2'h0);
    mrs(3'h1, 13'h0008);
    do_read(raddr(1'b0, 1'b0), 11, 8, 1'b0, 2'h0);
    mrs(3'h1, 13'h0000);
    $display("test array reads done");
    // eight-beat readouts keep the half bit low
    for (int loc = 0; loc < 4; loc++)
    begin
      mrs(3'h3, 13'(4 + loc));
      do_read(raddr(1'($random(seed)), 1'b0), 6, 8, 1'b1, 2'(loc));
    end
    stat("readout enabled", 4, 1'b1);
    mrs(3'h3, 13'h0004);
    mrs(3'h0, 13'h0022);
    do_read(raddr(1'b1, 1'b0), 6, 4, 1'b1, 2'h0);
    do_read(raddr(1'b0, 1'b1), 6, 4, 1'b1, 2'h0);
    mrs(3'h0, 13'h0021);
    do_read(raddr(1'b0, 1'b1), 6, 4, 1'b1, 2'h0);
    do_read(raddr(1'b1, 1'b0), 6, 8, 1'b1, 2'h0);
    ctl.send(3'h3, 3'h0, 14'h0000);
    gap(1);
    stat("bad command", 1, 1'b1);
    mrs(3'h3, 13'h0000);
    stat("readout enabled", 4, 1'b0);
    do_read(raddr(1'b0, 1'b1), 6, 4, 1'b0, 2'h0);
    mrs(3'h0, 13'h0020);
    $display("test calibration readout done");
    // loop-off switch
    // The clock change itself is not modelled; the bench keeps one rate
    mrs(3'h1, 13'h0001);
    stat("loop off", 3, 1'b1);
    do_read(raddr(1'b0, 1'b0), 5, 8, 1'b0, 2'h0);
    mrs(3'h3, 13'h0004);
    do_read(raddr(1'b0, 1'b0), 5, 8, 1'b1, 2'h0);
    mrs(3'h3, 13'h0000);
    mrs(3'h0, 13'h0030);
    stat("latency error", 2, 1'b1);
    mrs(3'h0, 13'h0020);
    stat("latency error", 2, 1'b0);
    mrs(3'h1, 13'h0000);
    stat("loop off", 3, 1'b0);
    do_read(raddr(1'b0, 1'b0), 6, 8, 1'b0, 2'h0);
    $display("test loop off done");
    // a read before lock is flagged but served
    @(negedge clk_i);
    dll_locked = 1'b0;
    gap(4);
    do_read(raddr(1'b0, 1'b0), 6, 8, 1'b0, 2'h0);
    stat("unlocked read", 0, 1'b1);
    $display("test unlocked read done");
    tally_and_finish();
  end
endmodule
